// ### inc/sbca_pkg.sv
package sbca_pkg;

	localparam int unsigned NUM_MASTERS = 7;
	localparam int unsigned NUM_EXT     = 6;
	localparam int unsigned NUM_CLKS    = 7;
	localparam int unsigned IDX_W       = 3;

	localparam logic [7:0] OFF_CLOCK_GATING_MASK = 8'hd9;
	localparam logic [7:0] OFF_CLOCK_RUN_STATE   = 8'hda;
	localparam logic [7:0] OFF_ARBITER_CONTROL   = 8'hdc;

	localparam logic [7:0] RST_CLOCK_GATING_MASK = 8'h00;
	localparam logic [7:0] RST_CLOCK_RUN_STATE   = 8'h00;
	localparam logic [7:0] RST_ARBITER_CONTROL   = 8'h40;

	localparam logic [7:0] GATING_WR_MASK = 8'h7f;
	localparam int unsigned BIT_PARK        = 7;
	localparam int unsigned BIT_BRIDGE_TIER = 6;
	localparam int unsigned BIT_STOPPED     = 0;

	localparam logic [2:0] OVR_GATE_A = 3'h2;
	localparam logic [2:0] OVR_GATE_B = 3'h3;

	// The bridge is master index 6; external masters sit at 0..5.
	localparam logic [IDX_W-1:0] BRIDGE_IDX = 3'h6;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} sbca_cfg_req_t;

	typedef struct packed {
		logic [NUM_EXT-1:0] ext;
		logic               bridge;
	} sbca_lines_t;

endpackage : sbca_pkg

// ### design/sbca_rr_tier.sv
`timescale 1ns/1ps
module sbca_rr_tier
	import sbca_pkg::*;
#(
	parameter int unsigned N = 7,
	parameter int unsigned W = 3
)
(
	input  wire logic [N-1:0] req_in,
	input  wire logic [W-1:0] last_in,
	output logic              found_out,
	output logic [W-1:0]      pick_out
);

	// Search starts just after the last winner so each requester gets a turn.
	always_comb
	begin
		int j;
		j         = 0;
		found_out = 1'b0;
		pick_out  = last_in;
		for (int k = N; k >= 1; k--)
		begin
			j = (int'(last_in) + k) % N;
			if (req_in[j])
			begin
				found_out = 1'b1;
				pick_out  = W'(j);
			end
		end
	end

endmodule : sbca_rr_tier

// ### design/sbca_ctl.sv
`timescale 1ns/1ps
// How it works
// RULE1 - A set gating bit stops its clock while override is 010b or 011b and power is exceeded.
// RULE2 - Outside that override code or without the power excess the gating bits do nothing.
// RULE3 - Gating bits 0 to 6 each drive the clock output of the same index; one stops it.
// RULE4 - Bit 7 of the gating register is reserved and reads zero.
// RULE5 - Status bit 0 reads one when clocks are stopped, zero when running, and ignores writes.
// RULE6 - Status bits 7 to 1 are reserved and read zero.
// RULE7 - The arbiter rotates within each of two tiers and serves the high tier first.
// RULE8 - Arbiter bit 7 set parks the idle bus on the bridge, clear parks it on the last master.
// RULE9 - Arbiter bit 6 puts the bridge in the high tier when one and the low tier when zero.
// RULE10 - Arbiter control bits 5 to 0 put grant lines 5 to 0 in the high tier when one.
// RULE11 - Express, global pin and power-on resets each return all bits to reset values.
// RULE12 - Arbiter control resets to 40h and the other two registers reset to zero.
// RULE13 - A gated clock restarts when its bit or condition clears; status tracks the outputs.
module sbca_ctl
	import sbca_pkg::*;
(
	input  wire logic                ref_clk_in,
	input  wire logic                rst_in,
	input  wire logic                pcie_reset_in,
	input  wire logic                global_reset_pin_n_in,
	input  wire logic                por_in,
	input  wire sbca_cfg_req_t       cfg_req_in,
	output logic [7:0]               cfg_rdata_out,
	output logic                     cfg_rvalid_out,
	input  wire logic [2:0]          power_override_field_in,
	input  wire logic                slot_power_exceeded_in,
	output logic [NUM_CLKS-1:0]      secondary_bus_clock_outputs_out,
	input  wire sbca_lines_t         bus_req_in,
	input  wire logic                bus_idle_in,
	output sbca_lines_t              bus_gnt_out
);

	logic                     any_reset;
	logic [7:0]               clock_gating_mask;
	logic [7:0]               secondary_clock_run_state;
	logic [7:0]               arbiter_priority_control;
	logic [7:0]               next_clock_gating_mask;
	logic [7:0]               next_secondary_clock_run_state;
	logic [7:0]               next_arbiter_priority_control;
	logic [7:0]               next_cfg_rdata;
	logic                     next_cfg_rvalid;
	logic [NUM_CLKS-1:0]      next_clk_run;
	logic                     gating_active;

	logic [NUM_MASTERS-1:0]   req_vec;
	logic [NUM_MASTERS-1:0]   tier_vec;
	logic [NUM_MASTERS-1:0]   hi_req;
	logic [NUM_MASTERS-1:0]   lo_req;
	logic                     hi_found;
	logic                     lo_found;
	logic [IDX_W-1:0]         hi_pick;
	logic [IDX_W-1:0]         lo_pick;
	logic [IDX_W-1:0]         hi_last;
	logic [IDX_W-1:0]         lo_last;
	logic [IDX_W-1:0]         owner;
	logic [IDX_W-1:0]         next_hi_last;
	logic [IDX_W-1:0]         next_lo_last;
	logic [IDX_W-1:0]         next_owner;

	// All reset sources are folded into one synchronous clear.
	assign any_reset = rst_in | pcie_reset_in | ~global_reset_pin_n_in | por_in; // RULE11

	// Register file: writes land on the next edge, reads answer one cycle later.
	always_comb
	begin
		next_clock_gating_mask        = clock_gating_mask;
		next_arbiter_priority_control = arbiter_priority_control;
		next_cfg_rdata                = cfg_rdata_out;
		next_cfg_rvalid               = cfg_req_in.rd;
		if (cfg_req_in.wr)
		begin
			unique case (cfg_req_in.addr)
				OFF_CLOCK_GATING_MASK:
				begin
					next_clock_gating_mask = cfg_req_in.wdata & GATING_WR_MASK; // RULE4
				end
				OFF_ARBITER_CONTROL:
				begin
					next_arbiter_priority_control = cfg_req_in.wdata;
				end
				default:
				begin
					next_clock_gating_mask = clock_gating_mask;
				end
			endcase
		end
		if (cfg_req_in.rd)
		begin
			unique case (cfg_req_in.addr)
				OFF_CLOCK_GATING_MASK: next_cfg_rdata = clock_gating_mask & GATING_WR_MASK; // RULE4
				OFF_CLOCK_RUN_STATE:   next_cfg_rdata = secondary_clock_run_state; // RULE5 RULE6
				OFF_ARBITER_CONTROL:   next_cfg_rdata = arbiter_priority_control;
				default:               next_cfg_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (any_reset)
		begin
			clock_gating_mask        <= RST_CLOCK_GATING_MASK; // RULE12
			arbiter_priority_control <= RST_ARBITER_CONTROL; // RULE12
			cfg_rdata_out            <= 8'h00;
			cfg_rvalid_out           <= 1'b0;
		end
		else
		begin
			clock_gating_mask        <= next_clock_gating_mask;
			arbiter_priority_control <= next_arbiter_priority_control;
			cfg_rdata_out            <= next_cfg_rdata;
			cfg_rvalid_out           <= next_cfg_rvalid;
		end
	end

	// Clock gating is re-evaluated every cycle, so clearing a bit or losing
	// the condition restarts the clock on the next edge.
	always_comb
	begin
		gating_active = ((power_override_field_in == OVR_GATE_A) ||
			(power_override_field_in == OVR_GATE_B)) && slot_power_exceeded_in; // RULE1 RULE2
		next_clk_run = ~(gating_active ? clock_gating_mask[NUM_CLKS-1:0]
			: {NUM_CLKS{1'b0}}); // RULE3 RULE13
		next_secondary_clock_run_state = 8'h00; // RULE6
		next_secondary_clock_run_state[BIT_STOPPED] = ~&next_clk_run; // RULE5 RULE13
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (any_reset)
		begin
			secondary_bus_clock_outputs_out <= {NUM_CLKS{1'b1}};
			secondary_clock_run_state       <= RST_CLOCK_RUN_STATE; // RULE12
		end
		else
		begin
			secondary_bus_clock_outputs_out <= next_clk_run;
			secondary_clock_run_state       <= next_secondary_clock_run_state;
		end
	end

	// Arbiter: requesters are split by tier, each tier rotates on its own.
	always_comb
	begin
		req_vec  = {bus_req_in.bridge, bus_req_in.ext};
		tier_vec = {arbiter_priority_control[BIT_BRIDGE_TIER],
			arbiter_priority_control[NUM_EXT-1:0]}; // RULE9 RULE10
		hi_req   = req_vec & tier_vec;
		lo_req   = req_vec & ~tier_vec;
	end

	sbca_rr_tier #(.N(NUM_MASTERS), .W(IDX_W)) u_hi_tier
	(
		.req_in    (hi_req),
		.last_in   (hi_last),
		.found_out (hi_found),
		.pick_out  (hi_pick)
	);

	sbca_rr_tier #(.N(NUM_MASTERS), .W(IDX_W)) u_lo_tier
	(
		.req_in    (lo_req),
		.last_in   (lo_last),
		.found_out (lo_found),
		.pick_out  (lo_pick)
	);

	// Ownership only moves while the bus is idle, so a transfer in flight
	// never loses its grant to a newcomer.
	always_comb
	begin
		next_owner   = owner;
		next_hi_last = hi_last;
		next_lo_last = lo_last;
		if (bus_idle_in)
		begin
			if (hi_found)
			begin
				next_owner   = hi_pick; // RULE7
				next_hi_last = hi_pick;
			end
			else if (lo_found)
			begin
				next_owner   = lo_pick; // RULE7
				next_lo_last = lo_pick;
			end
			else if (arbiter_priority_control[BIT_PARK])
			begin
				next_owner = BRIDGE_IDX; // RULE8
			end
			else
			begin
				next_owner = owner; // RULE8
			end
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (any_reset)
		begin
			owner   <= BRIDGE_IDX;
			hi_last <= BRIDGE_IDX;
			lo_last <= BRIDGE_IDX;
		end
		else
		begin
			owner   <= next_owner;
			hi_last <= next_hi_last;
			lo_last <= next_lo_last;
		end
	end

	always_comb
	begin
		bus_gnt_out.ext    = '0;
		bus_gnt_out.bridge = (owner == BRIDGE_IDX);
		for (int i = 0; i < NUM_EXT; i++)
		begin
			bus_gnt_out.ext[i] = (owner == IDX_W'(i));
		end
	end

endmodule : sbca_ctl

// ### tb/sbca_ctl_sva.sv
`timescale 1ns/1ps
module sbca_ctl_sva
	import sbca_pkg::*;
(
	input wire logic                ref_clk_in,
	input wire logic                rst_in,
	input wire logic                pcie_reset_in,
	input wire logic                global_reset_pin_n_in,
	input wire logic                por_in,
	input wire sbca_cfg_req_t       cfg_req_in,
	input wire logic [7:0]          cfg_rdata_out,
	input wire logic                cfg_rvalid_out,
	input wire logic [2:0]          power_override_field_in,
	input wire logic                slot_power_exceeded_in,
	input wire logic [NUM_CLKS-1:0] secondary_bus_clock_outputs_out,
	input wire sbca_lines_t         bus_req_in,
	input wire logic                bus_idle_in,
	input wire sbca_lines_t         bus_gnt_out
);
	logic rs;
	logic rdg;
	logic rds;
	logic gate;
	assign rs = rst_in | pcie_reset_in | ~global_reset_pin_n_in | por_in;
	assign rdg = cfg_req_in.rd && cfg_req_in.addr == OFF_CLOCK_GATING_MASK;
	assign rds = cfg_req_in.rd && cfg_req_in.addr == OFF_CLOCK_RUN_STATE;
	assign gate = power_override_field_in inside {OVR_GATE_A, OVR_GATE_B} && slot_power_exceeded_in;
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rs);
	a_gating_rsvd: assert property (rdg |=> cfg_rvalid_out && !cfg_rdata_out[7])
		else $error("gating bit 7 reads one");
	a_status_rsvd: assert property (rds |=> cfg_rvalid_out && cfg_rdata_out[7:1] == 7'h00)
		else $error("status upper bits not zero");
	a_status_track: assert property (rds |=> cfg_rdata_out[0] ==
		!(&$past(secondary_bus_clock_outputs_out))) else $error("status disagrees with clocks");
	a_no_gate: assert property (!gate |=> &secondary_bus_clock_outputs_out)
		else $error("clock stopped without gating condition");
	a_gnt_onehot: assert property ($onehot(bus_gnt_out))
		else $error("grant not one-hot");
	a_gnt_hold: assert property (!bus_idle_in |=> $stable(bus_gnt_out))
		else $error("grant moved on busy bus");
	a_gnt_req: assert property (bus_idle_in && bus_req_in != 7'h00 |=>
		(bus_gnt_out & $past(bus_req_in)) != 7'h00) else $error("grant missed requesters");
	// Written without the reset gate, since it checks what reset itself leaves behind.
	a_reset_vals: assert property (disable iff (1'b0) rs |=> !cfg_rvalid_out &&
		cfg_rdata_out == 8'h00 && &secondary_bus_clock_outputs_out && bus_gnt_out == 7'h01)
		else $error("reset values wrong");
	c_gated: cover property (!(&secondary_bus_clock_outputs_out));
	c_stop_read: cover property (cfg_rvalid_out && cfg_rdata_out[0]);
	c_ext_gnt: cover property (bus_idle_in && bus_gnt_out.ext != 6'h00);
endmodule : sbca_ctl_sva
bind sbca_ctl sbca_ctl_sva u_sva (.*);

// ### tb/sbca_bus_masters.sv
`timescale 1ns/1ps
module sbca_bus_masters
	import sbca_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	input  wire sbca_lines_t want_in,
	input  wire logic [3:0]  busy_len_in,
	input  wire sbca_lines_t gnt_in,
	output sbca_lines_t      req_out = '0,
	output logic             idle_out = 1'b1,
	output sbca_lines_t      served_out = '0
);
	logic [3:0]  cnt = 4'h0;
	sbca_lines_t r;
	// A master drops its request as its transfer starts, so the next idle edge sees only the rest.
	always @(posedge ref_clk_in)
	begin
		r = req_out | want_in;
		served_out <= '0;
		if (rst_in)
		begin
			r = '0;
			cnt <= 4'h0;
			idle_out <= 1'b1;
		end
		else if (cnt != 4'h0)
		begin
			cnt <= cnt - 4'h1;
			idle_out <= cnt == 4'h1;
		end
		else if (idle_out && (gnt_in & req_out) != '0)
		begin
			served_out <= gnt_in;
			r = r & ~gnt_in;
			cnt <= busy_len_in;
			idle_out <= 1'b0;
		end
		req_out <= r;
	end
endmodule : sbca_bus_masters

// ### tb/tb_sbca_ctl.sv
`timescale 1ns/1ps
module tb_sbca_ctl
	import sbca_pkg::*;
;
	localparam logic [7:0] A_MSK = OFF_CLOCK_GATING_MASK;
	localparam logic [7:0] A_RUN = OFF_CLOCK_RUN_STATE;
	localparam logic [7:0] A_ARB = OFF_ARBITER_CONTROL;
	logic          clk = 1'b0;
	logic [3:0]    rsv = 4'h1;
	sbca_cfg_req_t req = '0;
	logic [7:0]    rdata;
	logic          rvalid;
	logic [2:0]    ovr = 3'h0;
	logic          exc = 1'b0;
	logic [6:0]    clks;
	sbca_lines_t   breq, gnt, served;
	sbca_lines_t   want = '0;
	logic          idle;
	logic [3:0]    blen = 4'h3;
	int            n_errors = 0;
	int            n_compared = 0;
	always #10 clk = ~clk;
	sbca_ctl u_dut (.ref_clk_in(clk), .rst_in(rsv[0]), .pcie_reset_in(rsv[1]),
		.global_reset_pin_n_in(~rsv[2]), .por_in(rsv[3]), .cfg_req_in(req),
		.cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid), .power_override_field_in(ovr),
		.slot_power_exceeded_in(exc), .secondary_bus_clock_outputs_out(clks),
		.bus_req_in(breq), .bus_idle_in(idle), .bus_gnt_out(gnt));
	sbca_bus_masters u_bus (.ref_clk_in(clk), .rst_in(|rsv), .want_in(want),
		.busy_len_in(blen), .gnt_in(gnt), .req_out(breq), .idle_out(idle), .served_out(served));
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task chk(input bit ok, input string m);
		n_compared++;
		if (!ok)
		begin
			n_errors++;
			$display("Error %0t: %s", $time, m);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		req.addr = a;
		req.wdata = d;
		req.wr = 1'b1;
		cyc(1);
		req.wr = 1'b0;
		// An idle edge between strobes keeps each strobe a clean one-cycle pulse.
		cyc(1);
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		req.addr = a;
		req.rd = 1'b1;
		cyc(1);
		req.rd = 1'b0;
		chk(rvalid === 1'b1 && rdata === e, "read data");
		cyc(1);
	endtask : rd
	task post(input sbca_lines_t p);
		want = p;
		cyc(1);
		want = '0;
	endtask : post
	task srv(input int k);
		for (int i = 0; i < 100 && served === 7'h00; i++)
			cyc(1);
		chk(served === (k == 6 ? 7'h01 : 7'h02 << k), "grant order");
		cyc(1);
	endtask : srv
	task t_reset;
		for (int k = 0; k < 4; k++)
		begin
			wr(A_MSK, 8'h55);
			wr(A_ARB, 8'h81);
			rd(A_MSK, 8'h55);
			rsv = 4'h1 << k;
			cyc(1);
			rsv = 4'h0;
			rd(A_MSK, 8'h00);
			rd(A_ARB, 8'h40);
			rd(A_RUN, 8'h00);
			rd(8'he0, 8'h00);
		end
	endtask : t_reset
	task t_gate;
		bit g;
		wr(A_MSK, 8'ha5);
		wr(A_RUN, 8'hff);
		rd(A_MSK, 8'h25);
		for (int o = 0; o < 16; o++)
		begin
			ovr = o[2:0];
			exc = o[3];
			cyc(1);
			g = (o[2:0] == 3'h2 || o[2:0] == 3'h3) && o[3];
			chk(clks === (g ? 7'h5a : 7'h7f), "clock gate");
			rd(A_RUN, {7'h00, g});
		end
		ovr = 3'h2;
		cyc(1);
		chk(clks === 7'h5a, "clock gated");
		wr(A_MSK, 8'h00);
		cyc(1);
		chk(clks === 7'h7f, "clock resume");
		ovr = 3'h0;
		exc = 1'b0;
	endtask : t_gate
	task t_arb;
		int o1[7] = '{6, 0, 1, 2, 3, 4, 5};
		post(7'h7f);
		foreach (o1[i]) srv(o1[i]);
		wr(A_ARB, 8'h3f);
		blen = 4'h9;
		post(7'h29);
		srv(2);
		srv(4);
		srv(6);
		// The high tier last served ext4, so rotation must put ext5 ahead of ext1.
		post(7'h44);
		srv(5);
		srv(1);
		cyc(12);
		chk(gnt === 7'h04, "park on last");
		wr(A_ARB, 8'hbf);
		cyc(2);
		chk(gnt === 7'h01, "park on bridge");
		rd(A_ARB, 8'hbf);
	endtask : t_arb
	task end_sim;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	initial
	begin
		cyc(3);
		rsv = 4'h0;
		t_reset;
		t_gate;
		t_arb;
		end_sim;
	end
	// The whole run needs well under a thousand cycles; this bound leaves ample margin.
	initial
	begin
		repeat (5000) @(posedge clk);
		n_errors++;
		end_sim;
	end
endmodule : tb_sbca_ctl
